// ### dv/mct_bank_test.sv
// mct_bank_test.sv: self-checking bench for the counter-timer bank
`timescale 1ns/1ps
`default_nettype none
`include "mct_defines.svh"
module mct_bank_test import mct_pkg::*;;
  logic                  sys_clk = 1'h0;
  logic                  rst_n;
  logic [3:0]            runEn, irq, capPin, halted;
  mct_mode_e [3:0]       mode;
  logic [7:0]            cntEdge;
  logic [127:0]          prescaleTop, count, capValue;
  logic [511:0]          matchVal;
  mct_match_cfg_s [15:0] matchCfg;
  mct_cap_cfg_s [3:0]    capCfg;
  logic [19:0]           flagClr, flags;
  logic [15:0]           matchOut;
  int err_total = 0, checks_done = 0, seed = 98, n, p, m, w;
  mct_bank dut (.*);
  mct_pins pins (.*);
  always #12.5 sys_clk = ~sys_clk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %0t seen %0h want %0h", $time, seen, exp);
    end
  endtask : check
  // clocks between two reset-on-match events
  function automatic int period(input int mv, input int pv);
    return (mv + 1) * (pv + 1);
  endfunction : period
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : close_out
  task automatic restart();
    rst_n = 1'h0;
    {runEn, cntEdge, prescaleTop, matchVal, flagClr} = '0;
    {matchCfg, capCfg} = '0;
    for (int i = 0; i < 4; i++) mode[i] = MCT_TIMER;
    repeat (2) @(negedge sys_clk);
    rst_n = 1'h1;
  endtask : restart
  // bounded wait; a hang counts as a mismatch
  task automatic wait_flag(input int b, output int cyc);
    cyc = 0;
    while (flags[b] !== 1'h1) begin
      @(negedge sys_clk);
      cyc++;
      if (cyc > 5000) begin
        check(32'h0, 32'h1);
        close_out();
      end
    end
  endtask : wait_flag
  // ****
  // scenarios
  // ****
  initial begin
    for (int k = 0; k < 2; k++) begin
      restart();
      p = k ? ($random(seed) & 3) : 0;
      m = 1 + ($random(seed) & 7);
      prescaleTop[31:0] = p;
      matchVal[31:0] = m;
      matchCfg[0].intEn = 1'h1;
      matchCfg[0].resetOnMatch = 1'h1;
      runEn[0] = 1'h1;
      wait_flag(0, n);
      check(irq[0], 32'h1);
      check(count[31:0], 32'h0);
      flagClr[0] = 1'h1;
      @(negedge sys_clk) flagClr[0] = 1'h0;
      check(flags[0], 32'h0);
      wait_flag(0, n);
      check(n + 1, period(m, p));
    end
    $display("match reset done");
    restart();
    for (int k = 0; k < 4; k++) matchVal[k*32 +: 32] = (k < 3) ? k + 1 : 5;
    matchCfg[0].extAction = `MCT_EMA_LOW;
    matchCfg[1].extAction = `MCT_EMA_HIGH;
    matchCfg[2].extAction = `MCT_EMA_TOGGLE;
    matchCfg[3].stopOnMatch = 1'h1;
    matchCfg[3].resetOnMatch = 1'h1;
    runEn[0] = 1'h1;
    wait_flag(3, n);
    repeat (3) @(negedge sys_clk);
    check(halted[0], 32'h1);
    check(matchOut[3:0], 32'h6);
    matchCfg[0].extAction = `MCT_EMA_HIGH;
    matchCfg[1].extAction = `MCT_EMA_LOW;
    {runEn[0], flagClr[3]} = 2'h1;
    @(negedge sys_clk) {runEn[0], flagClr[3]} = 2'h2;
    wait_flag(3, n);
    check(matchOut[3:0], 32'h1);
    $display("match actions done");
    restart();
    runEn[1] = 1'h1;
    capCfg[1] = '{`MCT_EDGE_FALL, 1'h1, `MCT_EDGE_RISE};
    for (int k = 0; k < 3; k++) begin
      w = 3 + ($random(seed) & 15);
      pins.pulse(1, w);
      repeat (5) @(negedge sys_clk);
      // clear and capture share the sync delay: w clocks high gives w-1
      check(capValue[63:32], w - 1);
      check({flags[9], irq[1]}, 32'h3);
    end
    $display("pulse width done");
    restart();
    mode[3] = MCT_COUNTER;
    cntEdge[7:6] = `MCT_EDGE_RISE;
    runEn[3] = 1'h1;
    n = 1 + ($random(seed) & 7);
    for (int k = 0; k < n; k++) pins.pulse(3, 2);
    repeat (5) @(negedge sys_clk);
    check(count[111:96], n);
    $display("counter mode done");
    close_out();
  end
endmodule : mct_bank_test
bind mct_bank mct_chk #(.WW(WW)) chk (.*);
`default_nettype wire

// ### dv/mct_chk.sv
// mct_chk.sv: port assertions for the counter-timer bank
`timescale 1ns/1ps
`default_nettype none
// ****
// checker
// ****
module mct_chk import mct_pkg::*; #(
  parameter int WW = 32
) (
  input wire logic                  sys_clk,
  input wire logic                  rst_n,
  input wire logic [3:0]            runEn,
  input wire mct_mode_e [3:0]       mode,
  input wire logic [4*WW-1:0]       prescaleTop,
  input wire logic [16*WW-1:0]      matchVal,
  input wire mct_match_cfg_s [15:0] matchCfg,
  input wire mct_cap_cfg_s [3:0]    capCfg,
  input wire logic [3:0]            capPin,
  input wire logic [19:0]           flagClr,
  input wire logic [4*WW-1:0]       count,
  input wire logic [15:0]           matchOut,
  input wire logic [19:0]           flags,
  input wire logic [3:0]            irq,
  input wire logic [3:0]            halted
);
  logic       tick;
  logic [4:0] en0;
  // only watches instance 0 with no prescale and no capture clear
  assign tick = runEn[0] && !halted[0] && mode[0] == MCT_TIMER &&
                prescaleTop[31:0] == 32'h0 && capCfg[0].clrEdge == 2'h0;
  assign en0 = {capCfg[0].capIntEn, matchCfg[3].intEn, matchCfg[2].intEn,
                matchCfg[1].intEn, matchCfg[0].intEn};
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  chk_count_step: assert property ($changed(count[31:0]) |->
    count[31:0] == $past(count[31:0]) + 1 || count[31:0] == 32'h0)
    else $error("count jumped");
  chk_idle_hold: assert property ((!runEn[0] || halted[0]) &&
    capCfg[0].clrEdge == 2'h0 |=> $stable(count[31:0]))
    else $error("count moved while idle");
  chk_halt_keep: assert property (halted[0] && runEn[0] |=> halted[0])
    else $error("halt dropped");
  chk_match_clr: assert property (tick && count[31:0] == matchVal[31:0] &&
    matchCfg[0].resetOnMatch |=> count[31:0] == 32'h0 && flags[0])
    else $error("reset on match missed");
  chk_match_halt: assert property (tick &&
    count[31:0] == matchVal[63:32] && matchCfg[1].stopOnMatch |=> halted[0])
    else $error("stop on match missed");
  chk_pin_toggle: assert property (tick && count[31:0] == matchVal[95:64] &&
    matchCfg[2].extAction == 2'h3 |=> matchOut[2] != $past(matchOut[2]))
    else $error("toggle missed");
  chk_flag_sticky: assert property (flags[0] && !flagClr[0] |=> flags[0])
    else $error("flag lost");
  chk_irq_line: assert property (irq[0] == |(flags[4:0] & $past(en0)))
    else $error("irq wrong");
  chk_cap_flag: assert property ($fell(capPin[1]) && capCfg[1].capEdge[1]
    |-> ##[1:4] flags[9])
    else $error("capture flag missed");
  chk_cap_clear: assert property ($rose(capPin[1]) && capCfg[1].clrEdge[0]
    |-> ##[1:4] count[63:32] == 32'h0)
    else $error("capture clear missed");
  cover property (tick && count[31:0] == matchVal[31:0]);
  cover property ($rose(halted[0]));
  cover property ($fell(capPin[1]) ##[1:4] flags[9]);
endmodule : mct_chk
`default_nettype wire

// ### dv/mct_pins.sv
// mct_pins.sv: model of the external capture pins
`timescale 1ns/1ps
`default_nettype none
module mct_pins (
  input  wire logic     sys_clk,
  output var logic [3:0] capPin
);
  initial capPin = 4'h0;
  // edges land on falling clock edges, away from the sampling edge
  task automatic pulse(input int i, input int w);
    @(negedge sys_clk) capPin[i] = 1'h1;
    repeat (w) @(negedge sys_clk);
    capPin[i] = 1'h0;
  endtask : pulse
endmodule : mct_pins
`default_nettype wire

// ### rtl/mct_defines.svh
// mct_defines.svh: constants for the match/capture counter-timer
`ifndef MCT_DEFINES_SVH
`define MCT_DEFINES_SVH
`define MCT_WIDE_BITS      32
`define MCT_NARROW_BITS    16
`define MCT_NUM_WIDE       2
`define MCT_NUM_NARROW     2
`define MCT_NUM_MATCH      4
`define MCT_EMA_NONE       2'h0
`define MCT_EMA_LOW        2'h1
`define MCT_EMA_HIGH       2'h2
`define MCT_EMA_TOGGLE     2'h3
`define MCT_EDGE_RISE      2'h1
`define MCT_EDGE_FALL      2'h2
`define MCT_EDGE_BOTH      2'h3
`define MCT_IRQ_CAP_BIT    4
`endif

// ### rtl/mct_pkg.sv
// mct_pkg.sv: types for the match/capture counter-timer
package mct_pkg;
  typedef enum logic {MCT_TIMER, MCT_COUNTER} mct_mode_e;
  typedef struct packed {
    logic      intEn;
    logic      resetOnMatch;
    logic      stopOnMatch;
    logic [1:0] extAction;
  } mct_match_cfg_s;
  typedef struct packed {
    logic [1:0] capEdge;
    logic       capIntEn;
    logic [1:0] clrEdge;
  } mct_cap_cfg_s;
endpackage : mct_pkg

// ### rtl/mct_timer.sv
// mct_timer.sv: one counter/timer instance with prescaler, match, capture
`timescale 1ns/1ps
`default_nettype none
`include "mct_defines.svh"

module mct_timer import mct_pkg::*; #(
  parameter int W = `MCT_WIDE_BITS
) (
  input  wire logic                      sys_clk,
  input  wire logic                      rst_n,
  input  wire logic                      runEn,
  input  wire mct_mode_e                 mode,
  input  wire logic [1:0]                cntEdge,
  input  wire logic [W-1:0]              prescaleTop,
  input  wire logic [4*W-1:0]            matchVal,
  input  wire mct_match_cfg_s [3:0]      matchCfg,
  input  wire mct_cap_cfg_s              capCfg,
  input  wire logic                      capPin,
  input  wire logic [4:0]                flagClr,
  output logic [W-1:0]                   count,
  output logic [W-1:0]                   capValue,
  output logic [3:0]                     matchOut,
  output logic [4:0]                     flags,
  output logic                           irq,
  output logic                           halted
);

  // ********************************************************************
  // parameter check
  // ********************************************************************
  if (W < 2 || W > 32) begin : gBadW
    $error("mct_timer width out of range");
  end

  // ********************************************************************
  // pin synchronisers and edge detection
  // ********************************************************************
  logic [2:0]   capSync_ff;
  logic [W-1:0] cnt_ff;
  logic [W-1:0] pre_ff;
  logic [W-1:0] cap_ff;
  logic [3:0]   mOut_ff;
  logic [4:0]   flag_ff;
  logic         irq_ff;
  logic         halt_ff;

  // the pin is asynchronous: two stages settle it before logic reads it;
  // the third stage only remembers the last level for edge detection
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) capSync_ff <= 3'h0;
    else        capSync_ff <= {capSync_ff[1:0], capPin};
  end

  // an edge select of zero never fires, so an unused input stays quiet
  function automatic logic edgeHit(input logic [1:0] sel,
                                   input logic       rise,
                                   input logic       fall);
    logic hit;
    hit = 1'b0;
    if (sel[0] && rise) hit = 1'b1;
    if (sel[1] && fall) hit = 1'b1;
    edgeHit = hit;
  endfunction : edgeHit

  // ********************************************************************
  // edge selection
  // ********************************************************************
  wire pinRise = capSync_ff[1] & ~capSync_ff[2];
  wire pinFall = ~capSync_ff[1] & capSync_ff[2];
  wire capHit  = edgeHit(capCfg.capEdge, pinRise, pinFall);
  wire clrHit  = edgeHit(capCfg.clrEdge, pinRise, pinFall);
  wire cntHit  = edgeHit(cntEdge, pinRise, pinFall);

  // ********************************************************************
  // prescaler and advance
  // ********************************************************************
  // a halted or disabled instance freezes the count, except that a capture clear still zeroes it, and holds the prescaler at zero
  // a terminal value of zero advances the count on every clock
  wire running = runEn & ~halt_ff;
  wire preWrap = (pre_ff == prescaleTop);
  wire tick    = running & ((mode == MCT_TIMER) ? preWrap
                                                : cntHit);

  // ********************************************************************
  // match compare and actions
  // ********************************************************************
  // what a match does to its pin; none leaves the level as it is
  function automatic logic pinAction(input logic [1:0] act,
                                     input logic       cur);
    case (act)
      `MCT_EMA_LOW:    pinAction = 1'b0;
      `MCT_EMA_HIGH:   pinAction = 1'b1;
      `MCT_EMA_TOGGLE: pinAction = ~cur;
      default:         pinAction = cur;
    endcase
  endfunction : pinAction

  logic [3:0] mHit;
  logic [3:0] mReset;
  logic [3:0] mStop;
  logic [3:0] nxt_mOut;
  for (genvar i = 0; i < 4; i++) begin : gMatch
    // compare while the count holds the value, once per advance
    assign mHit[i]   = tick & (cnt_ff == matchVal[i*W +: W]);
    assign mReset[i] = mHit[i] & matchCfg[i].resetOnMatch;
    assign mStop[i]  = mHit[i] & matchCfg[i].stopOnMatch;
    always_comb begin
      nxt_mOut[i] = mOut_ff[i];
      if (mHit[i]) begin
        nxt_mOut[i] = pinAction(matchCfg[i].extAction, mOut_ff[i]);
      end
    end
  end

  wire anyReset = |mReset;
  wire anyStop  = |mStop;

  // ********************************************************************
  // next count and prescaler
  // ********************************************************************
  logic [W-1:0] nxt_cnt;
  logic [W-1:0] nxt_pre;

  // a capture clear beats a reset or stop match on the count, though a stop still halts; continue is the default
  always_comb begin
    if (clrHit) begin
      nxt_cnt = '0;
    end else if (anyReset) begin
      nxt_cnt = '0;
    end else if (anyStop) begin
      // stop freezes on the matched value rather than one past it
      nxt_cnt = cnt_ff;
    end else if (tick) begin
      nxt_cnt = cnt_ff + W'(1);
    end else begin
      nxt_cnt = cnt_ff;
    end
  end

  // prescaler sits at zero while idle or counting pin edges
  always_comb begin
    if (clrHit || !running || mode != MCT_TIMER) begin
      nxt_pre = '0;
    end else if (preWrap) begin
      nxt_pre = '0;
    end else begin
      nxt_pre = pre_ff + W'(1);
    end
  end

  // ********************************************************************
  // interrupt flags
  // ********************************************************************
  logic [4:0] flagSet;
  logic [4:0] flagEn;
  for (genvar i = 0; i < 4; i++) begin : gFlag
    assign flagSet[i] = mHit[i];
    assign flagEn[i]  = matchCfg[i].intEn;
  end
  assign flagSet[`MCT_IRQ_CAP_BIT] = capHit;
  assign flagEn[`MCT_IRQ_CAP_BIT]  = capCfg.capIntEn;
  // set beats a clear arriving in the same cycle
  wire [4:0] nxt_flag = flagSet | (flag_ff & ~flagClr);
  // a flag set while its enable is low raises the line once enabled
  wire       nxt_irq  = |(nxt_flag & flagEn);

  // ********************************************************************
  // registers
  // ********************************************************************
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) cnt_ff <= '0;
    else        cnt_ff <= nxt_cnt;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) pre_ff <= '0;
    else        pre_ff <= nxt_pre;
  end

  // capture takes the count as it stands before this edge's advance
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)      cap_ff <= '0;
    else if (capHit) cap_ff <= cnt_ff;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) mOut_ff <= 4'h0;
    else        mOut_ff <= nxt_mOut;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) flag_ff <= 5'h00;
    else        flag_ff <= nxt_flag;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) irq_ff <= 1'b0;
    else        irq_ff <= nxt_irq;
  end

  // halt holds until software drops runEn to rearm; a user must
  // take runEn low for one clock before the instance counts again
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) halt_ff <= 1'b0;
    else        halt_ff <= runEn & (halt_ff | anyStop);
  end

  // ********************************************************************
  // outputs, each straight from its register
  // ********************************************************************
  assign count    = cnt_ff;
  assign capValue = cap_ff;
  assign matchOut = mOut_ff;
  assign flags    = flag_ff;
  assign irq      = irq_ff;
  assign halted   = halt_ff;

endmodule : mct_timer

// ********************************************************************
// four-instance bank
// ********************************************************************
module mct_bank import mct_pkg::*; #(
  parameter int WW = `MCT_WIDE_BITS,
  parameter int NW = `MCT_NARROW_BITS
) (
  input  wire logic                  sys_clk,
  input  wire logic                  rst_n,
  input  wire logic [3:0]            runEn,
  input  wire mct_mode_e [3:0]       mode,
  input  wire logic [7:0]            cntEdge,
  input  wire logic [4*WW-1:0]       prescaleTop,
  input  wire logic [16*WW-1:0]      matchVal,
  input  wire mct_match_cfg_s [15:0] matchCfg,
  input  wire mct_cap_cfg_s [3:0]    capCfg,
  input  wire logic [3:0]            capPin,
  input  wire logic [19:0]           flagClr,
  output logic [4*WW-1:0]            count,
  output logic [4*WW-1:0]            capValue,
  output logic [15:0]                matchOut,
  output logic [19:0]                flags,
  output logic [3:0]                 irq,
  output logic [3:0]                 halted
);
  // ********************************************************************
  // parameter check
  // ********************************************************************
  // narrow slices come out of wide lanes, so narrow may not exceed wide
  if (WW < 2 || WW > 32 || NW < 2 || NW > WW) begin : gBadBank
    $error("mct_bank width out of range");
  end

  // ********************************************************************
  // timer instances
  // ********************************************************************
  // instances 0,1 wide, 2,3 narrow; narrow results zero-extended
  for (genvar t = 0; t < 4; t++) begin : gTmr
    localparam int TW = (t < `MCT_NUM_WIDE) ? WW : NW;
    logic [TW-1:0]   cntW;
    logic [TW-1:0]   capW;
    logic [4*TW-1:0] mv;
    for (genvar m = 0; m < 4; m++) begin : gMv
      assign mv[m*TW +: TW] = matchVal[(t*4+m)*WW +: TW];
    end
    mct_timer #(.W(TW)) uTmr (
      .sys_clk     (sys_clk),
      .rst_n       (rst_n),
      .runEn       (runEn[t]),
      .mode        (mode[t]),
      .cntEdge     (cntEdge[2*t +: 2]),
      .prescaleTop (prescaleTop[t*WW +: TW]),
      .matchVal    (mv),
      .matchCfg    (matchCfg[4*t +: 4]),
      .capCfg      (capCfg[t]),
      .capPin      (capPin[t]),
      .flagClr     (flagClr[5*t +: 5]),
      .count       (cntW),
      .capValue    (capW),
      .matchOut    (matchOut[4*t +: 4]),
      .flags       (flags[5*t +: 5]),
      .irq         (irq[t]),
      .halted      (halted[t])
    );
    assign count[t*WW +: WW]    = WW'(cntW);
    assign capValue[t*WW +: WW] = WW'(capW);
  end
endmodule : mct_bank
`default_nettype wire
